// [core/host_port_pkg.sv]
/*
 package for the parallel host port: widths, protocol codes, timing.
 assumes one 100 MHz clock and pins already synchronous to it.
*/
// Overview of operation
// - access needs address with chip select; strobes ignored while select inactive (latch strobe still opens mux mode and captures address without select).
// - width select low gives 8-bit data bus, high gives 16-bit bus.
// - latch strobe sampled in reset: high separate strobes, low direction strobe.
// - direction-plus-data-strobe protocol uses de-multiplexed buses only.
// - separate strobes: de-multiplexed while latch high, multiplexed after edge.
// - read strobe low reads, write strobe low writes.
// - de-multiplexed write captures address on write strobe falling edge.
// - multiplexed mode captures address from shared lines with latch strobe.
// - during reset every output driver, data bus included, is released.
// - direction selects read or write; data strobe with select times access.
package host_port_pkg;
   localparam int ADDR_W = 8;
   localparam int DATA_W = 16;
   localparam int CLK_PERIOD_NS = 10;
   localparam int RECOVERY_NS = 120;
   localparam int RECOVERY_CYC =
      (RECOVERY_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam logic [DATA_W-1:0] REG_RESET = 16'h0000;
   localparam logic [DATA_W-1:0] BYTE_MASK = 16'h00FF;
   typedef enum logic [1:0] {
      PROTO_SEP_DEMUX = 2'b00,
      PROTO_SEP_MUX = 2'b01,
      PROTO_DIR_STROBE = 2'b10
   } proto_t;
endpackage : host_port_pkg

// [core/host_reg_array.sv]
/*
 small register array behind the host port.
 assumes writes are single-cycle pulses from the port logic.
*/
`timescale 1ns/1ps
module host_reg_array (
   // clock and reset
   input wire logic i_clk,
   input wire logic i_resetn,
   // access
   input wire logic i_we,
   input wire logic [host_port_pkg::ADDR_W-1:0] i_addr,
   input wire logic [host_port_pkg::DATA_W-1:0] i_wdata,
   input wire logic [host_port_pkg::DATA_W-1:0] i_wmask,
   output logic [host_port_pkg::DATA_W-1:0] o_rdata
);
   localparam int DEPTH = 1 << host_port_pkg::ADDR_W;
   logic [host_port_pkg::DATA_W-1:0] mem_r [DEPTH];
   wire [host_port_pkg::DATA_W-1:0] old_w = mem_r[i_addr];
   wire [host_port_pkg::DATA_W-1:0] merged_w =
      (old_w & ~i_wmask) | (i_wdata & i_wmask);
   assign o_rdata = old_w;
   // contents survive reset only as cleared words
   always_ff @(posedge i_clk) begin
      if (!i_resetn) begin
         for (int k = 0; k < DEPTH; k++) begin
            mem_r[k] <= host_port_pkg::REG_RESET;
         end
      end else if (i_we) begin
         mem_r[i_addr] <= merged_w;
      end
   end
endmodule : host_reg_array

// [core/parallel_host_bus_interface.sv]
/*
 parallel host port: strobe protocols, address capture, tristate data.
 assumes host pins synchronous to i_clk; host keeps recovery spacing.
*/
`timescale 1ns/1ps
module parallel_host_bus_interface (
   // clock and reset
   input wire logic i_clk,
   input wire logic i_resetn,
   // straps and control
   input wire logic i_bus_width_select,
   input wire logic i_addr_latch,
   // strobes
   input wire logic i_chip_select_n,
   input wire logic i_read_n,
   input wire logic i_write_n,
   input wire logic i_direction,
   input wire logic i_data_strobe_n,
   // address and data
   input wire logic [host_port_pkg::ADDR_W-1:0] i_addr,
   input wire logic [host_port_pkg::DATA_W-1:0] i_data,
   output logic [host_port_pkg::DATA_W-1:0] o_data,
   output logic o_data_oe,
   // status
   output logic o_mux_mode,
   output logic o_dir_proto
);
   logic dir_proto_r;
   logic mux_r;
   logic ale_q_r;
   logic in_reset_r;
   logic rd_act_q_r;
   logic wr_act_q_r;
   logic [host_port_pkg::ADDR_W-1:0] addr_r;
   logic [host_port_pkg::ADDR_W-1:0] addr_nxt;
   logic [host_port_pkg::DATA_W-1:0] o_data_r;
   logic o_data_oe_r;
   logic [host_port_pkg::DATA_W-1:0] rdata_w;
   logic [host_port_pkg::DATA_W-1:0] wmask_w;

   wire cs_w = !i_chip_select_n;
   // direction protocol: direction high reads, low writes
   wire rd_act_w = cs_w && (dir_proto_r ? (!i_data_strobe_n && i_direction)
                                        : !i_read_n);
   wire wr_act_w = cs_w && (dir_proto_r ? (!i_data_strobe_n && !i_direction)
                                        : !i_write_n);
   wire wr_fall_w = wr_act_w && !wr_act_q_r;
   wire ale_edge_w = (i_addr_latch != ale_q_r) && !in_reset_r;
   wire [host_port_pkg::ADDR_W-1:0] mux_addr_w =
      i_data[host_port_pkg::ADDR_W-1:0];
   wire wide_w = i_bus_width_select;
   wire [host_port_pkg::DATA_W-1:0] width_mask_w =
      wide_w ? {host_port_pkg::DATA_W{1'b1}} : host_port_pkg::BYTE_MASK;
   // demux reads use the live address, writes the captured one
   wire [host_port_pkg::ADDR_W-1:0] acc_addr_w =
      mux_r ? addr_r : (wr_act_w ? addr_nxt : i_addr);

   assign wmask_w = width_mask_w;

   always_comb begin
      addr_nxt = addr_r;
      if (mux_r && i_addr_latch) begin
         addr_nxt = mux_addr_w;
      end else if (!mux_r && wr_fall_w) begin
         addr_nxt = i_addr;
      end
   end

   // strap is caught while reset is held, not by the reset itself
   always_ff @(posedge i_clk) begin
      if (!i_resetn) begin
         dir_proto_r <= !i_addr_latch;
         in_reset_r <= 1'b1;
      end else begin
         in_reset_r <= 1'b0;
      end
   end

   always_ff @(posedge i_clk) begin
      if (!i_resetn) begin
         mux_r <= 1'b0;
         ale_q_r <= 1'b1;
      end else begin
         ale_q_r <= i_addr_latch;
         if (!dir_proto_r && ale_edge_w) begin
            mux_r <= 1'b1;
         end
      end
   end

   always_ff @(posedge i_clk) begin
      if (!i_resetn) begin
         addr_r <= '0;
         rd_act_q_r <= 1'b0;
         wr_act_q_r <= 1'b0;
      end else begin
         addr_r <= addr_nxt;
         rd_act_q_r <= rd_act_w;
         wr_act_q_r <= wr_act_w;
      end
   end

   // write taken once per strobe, on its leading edge
   host_reg_array u_regs (
      .i_clk(i_clk),
      .i_resetn(i_resetn),
      .i_we(wr_fall_w),
      .i_addr(acc_addr_w),
      .i_wdata(i_data),
      .i_wmask(wmask_w),
      .o_rdata(rdata_w)
   );

   // one cycle late to release; host float time covers it
   always_ff @(posedge i_clk) begin
      if (!i_resetn) begin
         o_data_r <= '0;
         o_data_oe_r <= 1'b0;
      end else begin
         o_data_r <= rd_act_w ? (rdata_w & width_mask_w) : '0;
         o_data_oe_r <= rd_act_w;
      end
   end

   assign o_data = o_data_r;
   assign o_data_oe = o_data_oe_r;
   assign o_mux_mode = mux_r;
   assign o_dir_proto = dir_proto_r;
endmodule : parallel_host_bus_interface

// [tb/host_cpu_model.sv]
/* host processor model driving the port's strobes.
 assumes bench sets protocol before reset. */
`timescale 1ns/1ps
module host_cpu_model (
   input wire logic i_clk, i_oe,
   input wire logic [15:0] i_q,
   output logic o_ale, o_cs_n, o_rd_n, o_wr_n, o_dir, o_ds_n,
   output logic [7:0] o_a,
   output logic [15:0] o_d
);
   int m = 0;
   logic nocs = 1'h0;
   initial {o_ale, o_cs_n, o_rd_n, o_wr_n, o_dir, o_ds_n} = 6'h3F;
   initial {o_a, o_d} = 24'h0;
   task strap(input int md);
      m = md;
      o_ale = md != 2;
   endtask : strap
   task acc(input logic r, input logic [7:0] a, input logic [15:0] d,
      output logic [15:0] q);
      @(negedge i_clk);
      if (m == 1) begin
         // low first: the latch edge must open mux mode before capture
         o_ale = 1'h0;
         @(negedge i_clk);
         o_ale = 1'h1;
         o_d[7:0] = a;
         @(negedge i_clk);
         o_ale = 1'h0;
      end
      o_a = m == 1 ? ~a : a;
      o_d = r ? ~o_d : d;
      o_dir = r;
      o_cs_n = nocs;
      o_rd_n = !(r && m < 2);
      o_wr_n = !(!r && m < 2);
      o_ds_n = m < 2;
      repeat (6) @(negedge i_clk);
      q = i_oe ? i_q : 'x;
      {o_cs_n, o_rd_n, o_wr_n, o_ds_n} = 4'hF;
      o_a = ~o_a;
      o_d = ~o_d;
      repeat (host_port_pkg::RECOVERY_CYC) @(negedge i_clk);
   endtask : acc
endmodule : host_cpu_model

// [tb/host_port_sva.sv]
/* assertions on the host port pins.
 assumes one clock and the design's own reset. */
`timescale 1ns/1ps
module host_port_sva (
   input wire logic i_clk, i_resetn, i_bus_width_select, i_addr_latch,
   input wire logic i_chip_select_n, i_read_n, i_write_n, i_direction,
   input wire logic i_data_strobe_n,
   input wire logic [host_port_pkg::ADDR_W-1:0] i_addr,
   input wire logic [host_port_pkg::DATA_W-1:0] i_data, o_data,
   input wire logic o_data_oe, o_mux_mode, o_dir_proto
);
   default clocking @(posedge i_clk); endclocking
   default disable iff (!i_resetn);
   a_no_select: assert property (i_chip_select_n |=> !o_data_oe)
      else $error("bus driven without select");
   a_reset_quiet: assert property (disable iff (1'b0)
      !i_resetn |=> !o_data_oe && !o_mux_mode)
      else $error("driver active in reset");
   a_strap_pick: assert property (disable iff (1'b0)
      !i_resetn |=> o_dir_proto == !$past(i_addr_latch))
      else $error("protocol strap wrong");
   a_dir_demux: assert property (o_dir_proto |-> !o_mux_mode)
      else $error("mux mode in direction protocol");
   a_mux_cause: assert property ($rose(o_mux_mode) |->
      $past(i_addr_latch) != $past(i_addr_latch, 2) ||
      $past(i_addr_latch, 2) != $past(i_addr_latch, 3))
      else $error("mux mode without latch edge");
   a_read_drive: assert property (!o_dir_proto &&
      !i_chip_select_n && !i_read_n |=> o_data_oe)
      else $error("read not driven");
   a_dir_read: assert property (o_dir_proto && i_direction &&
      !i_chip_select_n && !i_data_strobe_n |=> o_data_oe)
      else $error("direction read not driven");
   a_oe_cause: assert property (o_data_oe |->
      $past(!i_chip_select_n && (o_dir_proto ?
      !i_data_strobe_n && i_direction : !i_read_n)))
      else $error("bus driven outside read");
   a_byte_width: assert property (o_data_oe &&
      !$past(i_bus_width_select) |-> o_data[15:8] == 8'h00)
      else $error("upper byte in 8-bit mode");
   cover property (o_data_oe);
   cover property ($rose(o_mux_mode));
   cover property (o_dir_proto && o_data_oe);
endmodule : host_port_sva

bind parallel_host_bus_interface host_port_sva sva_i (.*);

// [tb/parallel_host_bus_interface_bench.sv]
/* bench for the host port.
 assumes the processor model and the bound checker. */
`timescale 1ns/1ps
module parallel_host_bus_interface_bench;
   logic clk = 1'h0, rstn = 1'h0, wsel = 1'h1;
   logic ale, cs_n, rd_n, wr_n, dir, ds_n, oe, mux, dp;
   logic [7:0] a;
   logic [15:0] d, q, r;
   int bad_count = 0, n_compared = 0;
   typedef struct {logic r; logic [7:0] a; logic [15:0] d, e;} row_t;
   row_t rows[7] = '{'{1'h0, 8'h00, 16'h1234, 16'h0},
      '{1'h0, 8'hFF, 16'hABCD, 16'h0}, '{1'h1, 8'h00, 16'h0, 16'h1234},
      '{1'h1, 8'hFF, 16'h0, 16'hABCD}, '{1'h1, 8'h7E, 16'h0, 16'h0},
      '{1'h0, 8'h00, 16'h5A5A, 16'h0}, '{1'h1, 8'h00, 16'h0, 16'h5A5A}};
   always #5 clk = ~clk;
   host_cpu_model host (.i_clk(clk), .i_oe(oe), .i_q(q), .o_ale(ale),
      .o_cs_n(cs_n), .o_rd_n(rd_n), .o_wr_n(wr_n), .o_dir(dir),
      .o_ds_n(ds_n), .o_a(a), .o_d(d));
   parallel_host_bus_interface DUT (.i_clk(clk), .i_resetn(rstn),
      .i_bus_width_select(wsel), .i_addr_latch(ale), .i_chip_select_n(cs_n),
      .i_read_n(rd_n), .i_write_n(wr_n), .i_direction(dir),
      .i_data_strobe_n(ds_n), .i_addr(a), .i_data(d), .o_data(q),
      .o_data_oe(oe), .o_mux_mode(mux), .o_dir_proto(dp));
   task chk(input string n, input logic [15:0] s, e);
      n_compared++;
      if (s !== e) begin
         bad_count++;
         $display("BAD %s exp %h got %h", n, e, s);
      end
   endtask : chk
   task stop_test;
      $display("compared %0d bad %0d", n_compared, bad_count);
      if (bad_count == 0 && n_compared > 0)
         $display("bench passed");
      else
         $display("bench failed");
      $finish;
   endtask : stop_test
   task rst(input int md);
      @(negedge clk);
      host.strap(md);
      rstn = 1'h0;
      repeat (10) @(negedge clk);
      chk("oe", 16'(oe), 16'h0);
      chk("proto", 16'(dp), 16'(md == 2));
      rstn = 1'h1;
   endtask : rst
   task wr_rd(input logic [7:0] ad, input logic [15:0] v);
      host.acc(1'h0, ad, v, r);
      host.acc(1'h1, ad, 16'h0, r);
   endtask : wr_rd
   initial begin
      rst(0);
      foreach (rows[i]) begin
         host.acc(rows[i].r, rows[i].a, rows[i].d, r);
         if (rows[i].r) chk("row", r, rows[i].e);
      end
      host.nocs = 1'h1;
      host.acc(1'h0, 8'h00, 16'hFFFF, r);
      host.nocs = 1'h0;
      host.acc(1'h1, 8'h00, 16'h0, r);
      chk("nocs", r, 16'h5A5A);
      wsel = 1'h0;
      wr_rd(8'h10, 16'hA5C3);
      chk("byte", r, 16'h00C3);
      wsel = 1'h1;
      rst(2);
      wr_rd(8'h20, 16'hBEEF);
      chk("dir", r, 16'hBEEF);
      chk("dmux", 16'(mux), 16'h0);
      rst(1);
      chk("demux", 16'(mux), 16'h0);
      wr_rd(8'h30, 16'hC0DE);
      chk("mux", r, 16'hC0DE);
      chk("muxon", 16'(mux), 16'h1);
      stop_test;
   end
   initial begin
      #50000;
      bad_count++;
      stop_test;
   end
endmodule : parallel_host_bus_interface_bench
